// ---- hdl/jog_motion_pkg.sv ----
package jog_motion_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] CONTROL_OFFSET = 8'h00; // Control word
   localparam logic [7:0] CONFIG_OFFSET = 8'h04; // Direction select, servo on, reset
   localparam logic [7:0] VELOCITY_OFFSET = 8'h08; // Profile velocity
   localparam logic [7:0] ACCEL_OFFSET = 8'h0C; // Profile acceleration
   localparam logic [7:0] DECEL_OFFSET = 8'h10; // Profile deceleration
   localparam logic [7:0] STATUS_OFFSET = 8'h14; // Status, read only
   localparam logic [7:0] SPEED_OFFSET = 8'h18; // Present speed, read only

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int START_BIT = 4; // Control word: rotation start
   localparam int DIRECTION_BIT = 5; // Control word: direction
   localparam int HALT_BIT = 8; // Control word: halt
   localparam int TRAVEL_SELECT_BIT = 0; // Config: travel_direction_select
   localparam int SERVO_ON_BIT = 1; // Config: servo on
   localparam int CTRL_RESET_BIT = 2; // Config: control reset, self clearing
   localparam int ST_TARGET_BIT = 0; // Status: target reached
   localparam int ST_ROUGH_BIT = 1; // Status: rough_match_flag
   localparam int ST_TRAVEL_BIT = 2; // Status: travel_completion_flag
   localparam int ST_CW_BIT = 3; // Status: latched direction is clockwise
   localparam int ST_HELD_BIT = 4; // Status: temporary stop in effect
   localparam int ST_STATE_LSB = 8; // Status: one-hot state code

   // ------------------------------------------------------------
   // Widths and reset values
   // ------------------------------------------------------------
   localparam int SPEED_WIDTH = 16;
   localparam int CONTROL_WIDTH = 16;
   localparam int CONFIG_WIDTH = 3;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [2:0] CONFIG_RESET = 3'h0;
   localparam logic [15:0] VELOCITY_RESET = 16'h0000;
   localparam logic [15:0] ACCEL_RESET = 16'h0010;
   localparam logic [15:0] DECEL_RESET = 16'h0010;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 50; // 20 MHz
   localparam int RAMP_TICK_NS = 1000; // Speed profile update period
   localparam int RAMP_TICK_CYCLES = (RAMP_TICK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int TICK_COUNT_WIDTH = 5;
   localparam logic [4:0] TICK_LAST = 5'(RAMP_TICK_CYCLES - 1);

   // ------------------------------------------------------------
   // Motion sequencer states
   // ------------------------------------------------------------
   typedef enum logic [4:0]
   {
      IDLE = 5'b00001, // At rest, waiting for start
      RUN = 5'b00010, // Ramping toward velocity or cruising
      STOPPING = 5'b00100, // Start dropped, ramping down
      HALTING = 5'b01000, // Halt raised, ramping down
      HELD = 5'b10000 // Temporary stop
   } motion_state_type;

endpackage

// ---- hdl/jog_motion_control.sv ----
// Operation
// - Latch direction when start bit rises
// - Select 0: bit5 clear CCW, set CW
// - Select 1: bit5 clear CW, set CCW
// - Start runs with velocity, accel, decel
// - Cruising adopts new velocity without stopping
// - Velocity changes ignored while stopping or halting
// - Accel and decel accepted only at rest
// - Halt ramps down into temporary stop
// - Halt cleared with start held resumes
// - Halt cleared without start stays stopped
// - Start raised during temporary stop ignored
// - Servo-off, limit or reset ends hold
module jog_motion_control
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic limitDetected,
   output logic [15:0] motorSpeed,
   output logic motorClockwise,
   output logic targetReached,
   output logic rough_match_flag,
   output logic travel_completion_flag
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [15:0] controlWord; // Control word from master
   logic [2:0] setupBits; // Select, servo on, control reset
   logic [15:0] profileVelocity; // Last written velocity
   logic [15:0] profileAccel; // Active acceleration step
   logic [15:0] profileDecel; // Active deceleration step
   logic [15:0] activeVelocity; // Velocity the ramp aims at
   logic [15:0] speed; // Present motor speed
   logic [15:0] next_speed; // Speed after this tick
   jog_motion_pkg::motion_state_type state; // Sequencer state
   jog_motion_pkg::motion_state_type next_state; // Next sequencer state
   logic startPrev; // Start bit one cycle ago
   logic startDropped; // Start seen low during hold
   logic directionCw; // Latched direction
   logic limitMeta; // Synchroniser first stage
   logic limitSync; // Synchronised limit input
   logic [4:0] tickCount; // Ramp divider
   logic rampTick; // One-cycle ramp enable
   logic access; // APB access phase edge
   logic writeEnable; // Write takes effect
   logic atRest; // Stopped, no motion pending
   logic releaseHold; // Any event ending motion outright
   logic startBit;
   logic haltBit;

   assign startBit = controlWord[jog_motion_pkg::START_BIT];
   assign haltBit = controlWord[jog_motion_pkg::HALT_BIT];
   assign access = psel && penable && !pready;
   assign writeEnable = psel && penable && pready && pwrite;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------

   // Step speed toward a target; a zero step jumps there at once
   function automatic logic [15:0] rampToward
   (
      input logic [15:0] current,
      input logic [15:0] target,
      input logic [15:0] up,
      input logic [15:0] down
   );
      logic [16:0] sum;
      sum = 17'(current) + 17'(up);
      if (current < target)
      begin
         if (up == 16'h0000 || sum >= 17'(target))
            rampToward = target;
         else
            rampToward = sum[15:0];
      end
      else if (current > target)
      begin
         if (down == 16'h0000 || (current - target) <= down)
            rampToward = target;
         else
            rampToward = current - down;
      end
      else
         rampToward = current;
   endfunction

   // ------------------------------------------------------------
   // Input synchroniser
   // ------------------------------------------------------------

   // Limit switch comes from a pin, two flops before use
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         limitMeta <= 1'b0;
         limitSync <= 1'b0;
      end
      else
      begin
         limitMeta <= limitDetected;
         limitSync <= limitMeta;
      end
   end

   // ------------------------------------------------------------
   // Ramp divider
   // ------------------------------------------------------------

   // Profile updates once per tick, keeping step sizes usable
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         tickCount <= 5'h00;
         rampTick <= 1'b0;
      end
      else if (tickCount == jog_motion_pkg::TICK_LAST)
      begin
         tickCount <= 5'h00;
         rampTick <= 1'b1;
      end
      else
      begin
         tickCount <= tickCount + 5'h01;
         rampTick <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // APB register writes
   // ------------------------------------------------------------

   // Control word, config and velocity take every write
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         controlWord <= jog_motion_pkg::CONTROL_RESET;
         setupBits <= jog_motion_pkg::CONFIG_RESET;
         profileVelocity <= jog_motion_pkg::VELOCITY_RESET;
      end
      else
      begin
         // Control reset is a one-cycle pulse
         setupBits[jog_motion_pkg::CTRL_RESET_BIT] <= 1'b0;
         if (writeEnable)
         begin
            unique case (paddr)
               jog_motion_pkg::CONTROL_OFFSET:
                  controlWord <= pwdata[15:0];
               jog_motion_pkg::CONFIG_OFFSET:
                  setupBits <= pwdata[2:0];
               jog_motion_pkg::VELOCITY_OFFSET:
                  profileVelocity <= pwdata[15:0];
               default:
                  ;
            endcase
         end
      end
   end

   // Profile slopes change only with the motor at rest
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         profileAccel <= jog_motion_pkg::ACCEL_RESET;
         profileDecel <= jog_motion_pkg::DECEL_RESET;
      end
      else if (writeEnable && atRest)
      begin
         if (paddr == jog_motion_pkg::ACCEL_OFFSET)
            profileAccel <= pwdata[15:0];
         if (paddr == jog_motion_pkg::DECEL_OFFSET)
            profileDecel <= pwdata[15:0];
      end
   end

   // ------------------------------------------------------------
   // APB answer
   // ------------------------------------------------------------

   // One wait state; unmapped offsets answer with an error
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= access;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (access)
         begin
            unique case (paddr)
               jog_motion_pkg::CONTROL_OFFSET:
                  prdata <= {16'h0000, controlWord};
               jog_motion_pkg::CONFIG_OFFSET:
                  prdata <= {29'h00000000, setupBits};
               jog_motion_pkg::VELOCITY_OFFSET:
                  prdata <= {16'h0000, profileVelocity};
               jog_motion_pkg::ACCEL_OFFSET:
                  prdata <= {16'h0000, profileAccel};
               jog_motion_pkg::DECEL_OFFSET:
                  prdata <= {16'h0000, profileDecel};
               jog_motion_pkg::STATUS_OFFSET:
                  prdata <= {19'h00000, state, 3'h0, state == jog_motion_pkg::HELD,
                             directionCw, travel_completion_flag, rough_match_flag, targetReached};
               jog_motion_pkg::SPEED_OFFSET:
                  prdata <= {16'h0000, speed};
               default:
                  pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Motion sequencer
   // ------------------------------------------------------------

   // Servo-off, limit and control reset stop at once
   always_comb
   begin
      releaseHold = !setupBits[jog_motion_pkg::SERVO_ON_BIT] || limitSync
                    || setupBits[jog_motion_pkg::CTRL_RESET_BIT];
      atRest = (speed == 16'h0000)
               && (state == jog_motion_pkg::IDLE || state == jog_motion_pkg::HELD);
   end

   // Next state and next speed
   always_comb
   begin
      next_state = state;
      next_speed = speed;
      unique case (state)
         jog_motion_pkg::IDLE:
            if (startBit && !startPrev && !haltBit && !releaseHold)
               next_state = jog_motion_pkg::RUN;
         jog_motion_pkg::RUN:
         begin
            if (rampTick)
               next_speed = rampToward(speed, activeVelocity, profileAccel, profileDecel);
            if (releaseHold)
               next_state = jog_motion_pkg::IDLE;
            else if (haltBit)
               next_state = jog_motion_pkg::HALTING;
            else if (!startBit)
               next_state = jog_motion_pkg::STOPPING;
         end
         jog_motion_pkg::STOPPING, jog_motion_pkg::HALTING:
         begin
            if (rampTick)
               next_speed = rampToward(speed, 16'h0000, profileAccel, profileDecel);
            if (releaseHold)
               next_state = jog_motion_pkg::IDLE;
            else if (haltBit && state == jog_motion_pkg::STOPPING)
               next_state = jog_motion_pkg::HALTING;
            else if (next_speed == 16'h0000)
               next_state = (state == jog_motion_pkg::HALTING) ?
                            jog_motion_pkg::HELD : jog_motion_pkg::IDLE;
         end
         jog_motion_pkg::HELD:
         begin
            if (releaseHold)
               next_state = jog_motion_pkg::IDLE;
            else if (!haltBit)
            begin
               if (startBit && !startDropped)
                  next_state = jog_motion_pkg::RUN;
               else
                  next_state = jog_motion_pkg::IDLE;
            end
         end
      endcase
      // Abrupt stop on release events, as the drive loses control
      if (releaseHold)
         next_speed = 16'h0000;
   end

   // State, speed and start history
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state <= jog_motion_pkg::IDLE;
         speed <= 16'h0000;
         startPrev <= 1'b0;
      end
      else
      begin
         state <= next_state;
         speed <= next_speed;
         startPrev <= startBit;
      end
   end

   // Start must stay on through the hold for a resume
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         startDropped <= 1'b0;
      else if (state != jog_motion_pkg::HELD)
         startDropped <= 1'b0;
      else if (!startBit)
         startDropped <= 1'b1;
   end

   // Velocity target frozen while a stop or halt ramp-down runs
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         activeVelocity <= jog_motion_pkg::VELOCITY_RESET;
      else if (next_state == jog_motion_pkg::RUN || next_state == jog_motion_pkg::IDLE)
         activeVelocity <= profileVelocity;
   end

   // Direction latched only on the starting edge
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         directionCw <= 1'b0;
      else if (state == jog_motion_pkg::IDLE && next_state == jog_motion_pkg::RUN)
         directionCw <= controlWord[jog_motion_pkg::DIRECTION_BIT]
                        ^ setupBits[jog_motion_pkg::TRAVEL_SELECT_BIT];
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------

   // Flags follow the motor's rest, not the bits
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         motorSpeed <= 16'h0000;
         motorClockwise <= 1'b0;
         targetReached <= 1'b1;
         rough_match_flag <= 1'b1;
         travel_completion_flag <= 1'b1;
      end
      else
      begin
         motorSpeed <= next_speed;
         motorClockwise <= directionCw;
         targetReached <= (next_speed == 16'h0000) && (next_state == jog_motion_pkg::IDLE
                          || next_state == jog_motion_pkg::HELD);
         rough_match_flag <= (next_speed == 16'h0000) && (next_state == jog_motion_pkg::IDLE
                             || next_state == jog_motion_pkg::HELD);
         travel_completion_flag <= (next_speed == 16'h0000) && (next_state == jog_motion_pkg::IDLE
                                   || next_state == jog_motion_pkg::HELD);
      end
   end

endmodule

// ---- dv/jog_motion_control_asserts.sv ----
module jog_motion_control_asserts
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] motorSpeed,
   input wire logic motorClockwise,
   input wire logic targetReached,
   input wire logic rough_match_flag,
   input wire logic travel_completion_flag
);
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------
   // One clock domain, one reset
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Access phase still waiting for its answer
   sequence s_access;
      psel && penable && !pready;
   endsequence

   // ----------------------------------------
   // Bus answer
   // ----------------------------------------
   a_answer_next: assert property (s_access |=> pready) else $error("no answer after access");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   a_quiet_bus: assert property (!pready |-> prdata == 32'h00000000 && !pslverr) else $error("bus not quiet");
   a_error_empty: assert property (pready && pslverr |-> prdata == 32'h00000000) else $error("error with data");

   // ----------------------------------------
   // Motion status
   // ----------------------------------------
   a_flags_moving: assert property (
      motorSpeed != 16'h0000 |-> !(targetReached || rough_match_flag || travel_completion_flag))
      else $error("rest flag while moving");
   a_flags_together: assert property (
      targetReached == rough_match_flag && targetReached == travel_completion_flag)
      else $error("rest flags disagree");
   // Direction may only move when a move begins
   a_dir_latched: assert property ($changed(motorClockwise) |-> !targetReached)
      else $error("direction changed at rest");
   // Profile steps come once per tick, never faster; a release event may still drop speed to zero
   a_ramp_tick: assert property (
      $changed(motorSpeed) && motorSpeed != 16'h0000 |=> ($stable(motorSpeed) || motorSpeed == 16'h0000)[*8])
      else $error("speed stepped off tick");
endmodule

// ---- dv/apb_master_model.sv ----
module apb_master_model
(
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------
   // Idle bus at time zero
   // ----------------------------------------
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end

   // ----------------------------------------
   // One transfer: setup, access until ready
   // ----------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err, output logic ok);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // Bounded so a dead slave cannot hang the run
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      q = prdata;
      err = pslverr;
      ok = (pready === 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Stale values are not left on the bus
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// ---- dv/jog_motion_control_test.sv ----
module jog_motion_control_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk, reset_n, limitDetected, psel, penable, pwrite, pready, pslverr, err, ok;
   logic motorClockwise, targetReached, roughMatchFlag, travelCompletionFlag;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, seed;
   logic [15:0] motorSpeed, vel;
   int bad_count, cmp_count;
   wire logic [31:0] flags = {29'h0, targetReached, roughMatchFlag, travelCompletionFlag};

   jog_motion_control jog_motion_control_i (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .limitDetected(limitDetected), .motorSpeed(motorSpeed), .motorClockwise(motorClockwise),
      .targetReached(targetReached), .rough_match_flag(roughMatchFlag),
      .travel_completion_flag(travelCompletionFlag));
   apb_master_model apb_master_model_i (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // Clock, 50 ns period
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Bus access; a missing answer ends the run
   task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
      apb_master_model_i.xfer(wr, a, d, q, err, ok);
      if (!ok)
      begin
         check("pready", 32'h00000001, 32'h00000000);
         wrap_up();
      end
   endtask

   // Bounded wait for a speed value
   task automatic wait_speed(input logic [15:0] v);
      int n;
      n = 0;
      while (motorSpeed !== v && n < 4000)
      begin
         @(posedge clk);
         n++;
      end
      check("speed", {16'h0000, v}, {16'h0000, motorSpeed});
      if (n == 4000)
         wrap_up();
      repeat (2) @(posedge clk);
   endtask

   // Fresh start edge, then halt into a temporary stop
   task automatic enter_hold();
      access(1'b1, jog_motion_pkg::CONTROL_OFFSET, 32'h00000000);
      access(1'b1, jog_motion_pkg::CONTROL_OFFSET, 32'h00000010);
      repeat (30) @(posedge clk);
      access(1'b1, jog_motion_pkg::CONTROL_OFFSET, 32'h00000110);
      wait_speed(16'h0000);
      access(1'b0, jog_motion_pkg::STATUS_OFFSET, 32'h00000000);
      check("held", 32'h00001017, q & 32'h00001017);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      reset_n = 1'b0;
      limitDetected = 1'b0;
      seed = 32'h5AED6093;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      // Reset values and an unmapped place
      access(1'b0, jog_motion_pkg::ACCEL_OFFSET, 32'h00000000);
      check("accel", 32'h00000010, q);
      access(1'b0, jog_motion_pkg::STATUS_OFFSET, 32'h00000000);
      check("status", 32'h00000107, q);
      access(1'b0, 8'h1C, 32'h00000000);
      check("slverr", 32'h00000001, {31'h0, err});
      // Accel taken at rest
      access(1'b1, jog_motion_pkg::ACCEL_OFFSET, 32'h00000020);
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         vel = 16'h0040 + {9'h0, seed[6:5], 5'h00};
         access(1'b1, jog_motion_pkg::CONFIG_OFFSET, {30'h0, 1'b1, i[0]});
         access(1'b1, jog_motion_pkg::VELOCITY_OFFSET, {16'h0000, vel});
         access(1'b1, jog_motion_pkg::CONTROL_OFFSET, {26'h0, i[1], 5'h10});
         wait_speed(vel);
         check("cw", {31'h0, i[0] ^ i[1]}, {31'h0, motorClockwise});
         check("flags", 32'h00000000, flags);
         // Direction bit flipped mid-move is not taken
         access(1'b1, jog_motion_pkg::CONTROL_OFFSET, {26'h0, ~i[1], 5'h10});
         check("cw kept", {31'h0, i[0] ^ i[1]}, {31'h0, motorClockwise});
         access(1'b1, jog_motion_pkg::ACCEL_OFFSET, 32'h00000030);
         access(1'b0, jog_motion_pkg::ACCEL_OFFSET, 32'h00000000);
         check("accel", 32'h00000020, q);
         access(1'b1, jog_motion_pkg::VELOCITY_OFFSET, {16'h0000, vel + 16'h0020});
         wait_speed(vel + 16'h0020);
         // Velocity write during ramp-down must not lift speed
         access(1'b1, jog_motion_pkg::CONTROL_OFFSET, 32'h00000000);
         access(1'b1, jog_motion_pkg::VELOCITY_OFFSET, 32'h0000FFFF);
         vel = motorSpeed;
         repeat (21) @(posedge clk);
         check("ramp down", 32'h00000001, {31'h0, motorSpeed < vel});
         wait_speed(16'h0000);
         check("flags", 32'h00000007, flags);
      end
      // Halt released with start held resumes
      access(1'b1, jog_motion_pkg::VELOCITY_OFFSET, 32'h00000040);
      enter_hold();
      access(1'b1, jog_motion_pkg::CONTROL_OFFSET, 32'h00000010);
      repeat (45) @(posedge clk);
      check("resume", 32'h00000001, {31'h0, motorSpeed != 16'h0000});
      // Halt released without start stays put
      access(1'b1, jog_motion_pkg::CONTROL_OFFSET, 32'h00000110);
      wait_speed(16'h0000);
      access(1'b1, jog_motion_pkg::CONTROL_OFFSET, 32'h00000000);
      repeat (45) @(posedge clk);
      check("no resume", 32'h00000000, {16'h0000, motorSpeed});
      // Start raised anew during the hold is ignored
      enter_hold();
      access(1'b1, jog_motion_pkg::CONTROL_OFFSET, 32'h00000100);
      access(1'b1, jog_motion_pkg::CONTROL_OFFSET, 32'h00000110);
      // Halt cleared too: start was not held through the stop
      access(1'b1, jog_motion_pkg::CONTROL_OFFSET, 32'h00000010);
      repeat (45) @(posedge clk);
      check("no start", 32'h00000000, {16'h0000, motorSpeed});
      // Servo off, limit, control reset each end the hold
      for (int k = 0; k < 3; k++)
      begin
         enter_hold();
         if (k == 1)
            limitDetected <= 1'b1;
         else
            access(1'b1, jog_motion_pkg::CONFIG_OFFSET, (k == 0) ? 32'h00000000 : 32'h00000006);
         repeat (4) @(posedge clk);
         access(1'b0, jog_motion_pkg::STATUS_OFFSET, 32'h00000000);
         check("released", 32'h00000001, {27'h0, q[12:8]});
         limitDetected <= 1'b0;
         access(1'b1, jog_motion_pkg::CONFIG_OFFSET, 32'h00000002);
      end
      wrap_up();
   end
endmodule

bind jog_motion_control jog_motion_control_asserts jog_motion_control_asserts_i (.clk(clk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .motorSpeed(motorSpeed),
   .motorClockwise(motorClockwise), .targetReached(targetReached), .rough_match_flag(rough_match_flag),
   .travel_completion_flag(travel_completion_flag));
